// ==== hw/mcrb_pkg.sv ====
// Constants and types shared by the connection register bank
package mcrb_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PD_AW  = 9;

  // Process data windows; the bases are 512-word aligned
  localparam logic [15:0] IN_BASE      = 16'h0000;
  localparam logic [15:0] IN_LAST      = 16'h01ff;
  localparam logic [15:0] ALT_IN_BASE  = 16'h8000;
  localparam logic [15:0] ALT_IN_LAST  = 16'h81ff;
  localparam logic [15:0] OUT_BASE     = 16'h0800;
  localparam logic [15:0] OUT_LAST     = 16'h09ff;
  localparam logic [15:0] ALT_OUT_BASE = 16'h9000;
  localparam logic [15:0] ALT_OUT_LAST = 16'h91ff;

  localparam logic [15:0] ADDR_MODULE_STATUS  = 16'h100c;
  localparam logic [15:0] ADDR_WD_ELAPSED     = 16'h1020;
  localparam logic [15:0] ADDR_WD_PRESET      = 16'h1120;
  localparam logic [15:0] ADDR_CONN_MODE      = 16'h1130;
  localparam logic [15:0] ADDR_IDLE_TIMEOUT   = 16'h1131;
  localparam logic [15:0] ADDR_RESTORE_KEY1   = 16'h113c;
  localparam logic [15:0] ADDR_RESTORE_KEY2   = 16'h113d;
  localparam logic [15:0] ADDR_SAVE_KEY1      = 16'h113e;
  localparam logic [15:0] ADDR_SAVE_KEY2      = 16'h113f;
  localparam logic [15:0] ADDR_PROTO_DISABLE  = 16'h1140;
  localparam logic [15:0] ADDR_PROTO_ACTIVE   = 16'h1141;
  localparam logic [15:0] ADDR_UV_LED_STYLE   = 16'h1150;
  localparam logic [15:0] ADDR_PRI_SUPPLY     = 16'h2400;
  localparam logic [15:0] ADDR_SEC_SUPPLY     = 16'h2401;

  localparam logic [15:0] RESTORE_KEY1 = 16'h6c6f;
  localparam logic [15:0] RESTORE_KEY2 = 16'h6164;
  localparam logic [15:0] SAVE_KEY1    = 16'h7361;
  localparam logic [15:0] SAVE_KEY2    = 16'h7665;

  localparam int unsigned MODE_SINGLE_BIT    = 0;
  localparam int unsigned MODE_IMMEDIATE_BIT = 1;
  localparam int unsigned PROTO_MODBUS_BIT   = 1;

  localparam logic [15:0] WD_PRESET_DEF     = 16'h01f4;
  localparam logic [1:0]  CONN_MODE_DEF     = 2'h0;
  localparam logic [15:0] IDLE_TIMEOUT_DEF  = 16'h0000;
  localparam logic [15:0] PROTO_DISABLE_DEF = 16'h0000;
  localparam logic [15:0] PROTO_ACTIVE_DEF  = 16'h0002;

  localparam logic [7:0] EXC_NONE         = 8'h00;
  localparam logic [7:0] EXC_NO_AUTH      = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;

  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned ONE_SECOND_NS  = 1_000_000_000;
  localparam int unsigned SEC_CYCLES_DEF = ONE_SECOND_NS / CLK_PERIOD_NS;
  localparam logic [4:0]  KEY_WINDOW_S   = 5'h1e;

  typedef enum logic [1:0] {RG_NONE, RG_IN, RG_OUT, RG_REG} mcrb_region_type;

endpackage

// ==== hw/mcrb_dpram.sv ====
// Two-port word memory with registered read data
`timescale 1ns/10ps
module mcrb_dpram #(
  parameter int unsigned AW = 9,
  parameter int unsigned DW = 16
)(
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  input  wire logic          a_en_i,
  input  wire logic          a_we_i,
  input  wire logic [AW-1:0] a_addr_i,
  input  wire logic [DW-1:0] a_wdata_i,
  output logic      [DW-1:0] a_rdata_o,
  input  wire logic          b_en_i,
  input  wire logic          b_we_i,
  input  wire logic [AW-1:0] b_addr_i,
  input  wire logic [DW-1:0] b_wdata_i,
  output logic      [DW-1:0] b_rdata_o
);

  logic [DW-1:0] mem [2**AW];

  // Port A is listed last so it wins a same-word collision
  always_ff @(posedge mclk_i)
  begin
    if (b_en_i && b_we_i)
      mem[b_addr_i] <= b_wdata_i;
    if (a_en_i && a_we_i)
      mem[a_addr_i] <= a_wdata_i;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      a_rdata_o <= '0;
      b_rdata_o <= '0;
    end
    else
    begin
      if (a_en_i)
        a_rdata_o <= mem[a_addr_i];
      if (b_en_i)
        b_rdata_o <= mem[b_addr_i];
    end
  end

endmodule

// ==== hw/mcrb_top.sv ====
// Connection register bank: decode, write authorization, idle timeout, key sequences
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// [R1] Input process data also readable, read only, at 0x8000 window.
// [R2] Output window at 0x9000 aliases 0x0800 storage for read and write.
// [R3] Secondary supply millivolts read at 0x2401; zero during undervoltage.
// [R4] Mode bit 0 clear: every open connection may write.
// [R5] Mode bit 0 set: one writer holds permission until it disconnects.
// [R6] Mode bit 1 clear: first write requests permission; refusal gives exception 0x01.
// [R7] Mode bit 1 set: permission granted at connect; single mode only first.
// [R8] Idle connection closed after timeout seconds; zero never closes.
// [R9] Modbus active, timeout occurred, no connection left: bus indicator flashes green.
// [R10] Keys 0x6c6f then 0x6164 within 30 s restore parameter defaults; code restores preset, mode and idle timeout, not protocol disable/active.
// [R11] Restore changes working copies only, nothing saved.
// [R12] Keys 0x7361 then 0x7665 within 30 s save parameters non-volatile.
// [R13] Both keys accepted in one multi-register write, in address order.
// [R14] Watchdog preset at 0x1120 read/write milliseconds, default 500.
// [R15] Wrong or late second key abandons sequence; first key needed again.
////////////////////////////////////////////////////////////////////////////////
module mcrb_top #(
  parameter int unsigned NCONN      = 4,
  parameter int unsigned CONN_W     = $clog2(NCONN),
  parameter int unsigned SEC_CYCLES = mcrb_pkg::SEC_CYCLES_DEF
)(
  input  wire logic                            mclk_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            req_valid_i,
  input  wire logic                            req_write_i,
  input  wire logic [CONN_W-1:0]               req_conn_i,
  input  wire logic [mcrb_pkg::ADDR_W-1:0]     req_addr_i,
  input  wire logic [mcrb_pkg::DATA_W-1:0]     req_wdata_i,
  output logic                                 rsp_valid_o,
  output logic      [mcrb_pkg::DATA_W-1:0]     rsp_rdata_o,
  output logic      [7:0]                      rsp_exc_o,
  input  wire logic [NCONN-1:0]                conn_open_i,
  input  wire logic [NCONN-1:0]                conn_activity_i,
  output logic      [NCONN-1:0]                conn_close_o,
  output logic      [NCONN-1:0]                write_auth_o,
  input  wire logic [mcrb_pkg::DATA_W-1:0]     module_status_i,
  input  wire logic [mcrb_pkg::DATA_W-1:0]     watchdog_elapsed_ms_i,
  input  wire logic                            power_led_undervolt_style_i,
  input  wire logic [mcrb_pkg::DATA_W-1:0]     primary_supply_mv_i,
  input  wire logic                            primary_uv_i,
  input  wire logic [mcrb_pkg::DATA_W-1:0]     secondary_supply_mv_i,
  input  wire logic                            secondary_uv_i,
  input  wire logic                            in_pd_we_i,
  input  wire logic [mcrb_pkg::PD_AW-1:0]      in_pd_addr_i,
  input  wire logic [mcrb_pkg::DATA_W-1:0]     in_pd_wdata_i,
  input  wire logic [mcrb_pkg::PD_AW-1:0]      out_pd_addr_i,
  output logic      [mcrb_pkg::DATA_W-1:0]     out_pd_rdata_o,
  output logic      [mcrb_pkg::DATA_W-1:0]     watchdog_preset_ms_o,
  output logic      [1:0]                      connection_mode_o,
  output logic      [mcrb_pkg::DATA_W-1:0]     idle_timeout_s_o,
  output logic      [mcrb_pkg::DATA_W-1:0]     protocol_disable_o,
  output logic      [mcrb_pkg::DATA_W-1:0]     protocol_active_o,
  output logic                                 nvm_save_o,
  output logic                                 bus_led_flash_green_o
);
  import mcrb_pkg::*;

  mcrb_region_type region;
  logic            reg_rw;
  logic [15:0]     reg_rdata;
  logic            addr_ok;
  logic            auth_ok;
  logic            do_write;
  logic [7:0]      req_exc;
  logic [NCONN-1:0] next_auth;
  logic [NCONN-1:0] conn_q;
  logic [NCONN-1:0] conn_rise;
  logic [NCONN-1:0] idle_hit;
  logic [15:0]     idle_cnt [NCONN];
  logic [31:0]     sec_cnt;
  logic            sec_tick;
  logic [1:0]      key_armed;
  logic [1:0]      key_fire;
  logic            timeout_seen;
  logic            s1_valid;
  logic            s1_write;
  mcrb_region_type s1_region;
  logic [7:0]      s1_exc;
  logic [15:0]     s1_rdata;
  logic [15:0]     in_rdata;
  logic [15:0]     out_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  always_comb
  begin
    region    = RG_NONE;
    reg_rdata = 16'h0000;
    reg_rw    = req_addr_i inside {ADDR_WD_PRESET, ADDR_CONN_MODE, ADDR_IDLE_TIMEOUT,
                                   ADDR_RESTORE_KEY1, ADDR_RESTORE_KEY2, ADDR_SAVE_KEY1,
                                   ADDR_SAVE_KEY2, ADDR_PROTO_DISABLE, ADDR_PROTO_ACTIVE};
    if (req_addr_i <= IN_LAST || (req_addr_i >= ALT_IN_BASE && req_addr_i <= ALT_IN_LAST))
      region = RG_IN; // [R1]
    else if ((req_addr_i >= OUT_BASE && req_addr_i <= OUT_LAST) ||
             (req_addr_i >= ALT_OUT_BASE && req_addr_i <= ALT_OUT_LAST))
      region = RG_OUT; // [R2]
    else
    begin
      region = RG_REG;
      case (req_addr_i)
        ADDR_MODULE_STATUS: reg_rdata = module_status_i;
        ADDR_WD_ELAPSED:    reg_rdata = watchdog_elapsed_ms_i;
        ADDR_WD_PRESET:     reg_rdata = watchdog_preset_ms_o; // [R14]
        ADDR_CONN_MODE:     reg_rdata = {14'h0000, connection_mode_o};
        ADDR_IDLE_TIMEOUT:  reg_rdata = idle_timeout_s_o;
        ADDR_PROTO_DISABLE: reg_rdata = protocol_disable_o;
        ADDR_PROTO_ACTIVE:  reg_rdata = protocol_active_o;
        ADDR_UV_LED_STYLE:  reg_rdata = {15'h0000, power_led_undervolt_style_i};
        ADDR_PRI_SUPPLY:    reg_rdata = primary_uv_i ? 16'h0000 : primary_supply_mv_i;
        ADDR_SEC_SUPPLY:    reg_rdata = secondary_uv_i ? 16'h0000 : secondary_supply_mv_i; // [R3]
        ADDR_RESTORE_KEY1, ADDR_RESTORE_KEY2, ADDR_SAVE_KEY1, ADDR_SAVE_KEY2:
          reg_rdata = 16'h0000;
        default:            region = RG_NONE;
      endcase
    end
  end

  // Read-only windows refuse writes as an illegal address
  assign addr_ok = region != RG_NONE &&
                   !(req_write_i && !(region == RG_OUT || (region == RG_REG && reg_rw))); // [R1]
  // Only the single-writer mode can refuse a write for lack of permission
  assign auth_ok = write_auth_o[req_conn_i] || !connection_mode_o[MODE_SINGLE_BIT] ||
                   !(|write_auth_o); // [R4] [R5] [R6]
  assign do_write = req_valid_i && req_write_i && addr_ok && auth_ok;
  assign req_exc  = !addr_ok ? EXC_ILLEGAL_ADDR :
                    (req_write_i && !auth_ok) ? EXC_NO_AUTH : EXC_NONE; // [R6]

  //////////////////////////////////////////////////////////////////////////////
  // Process data storage

  // Both aliases share the low index bits, so one index serves either window
  mcrb_dpram #(.AW(PD_AW), .DW(DATA_W)) u_in_pd (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .a_en_i    (req_valid_i && !req_write_i && region == RG_IN),
    .a_we_i    (1'b0),
    .a_addr_i  (req_addr_i[PD_AW-1:0]),
    .a_wdata_i (16'h0000),
    .a_rdata_o (in_rdata),
    .b_en_i    (in_pd_we_i),
    .b_we_i    (in_pd_we_i),
    .b_addr_i  (in_pd_addr_i),
    .b_wdata_i (in_pd_wdata_i),
    .b_rdata_o ()
  );

  mcrb_dpram #(.AW(PD_AW), .DW(DATA_W)) u_out_pd (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .a_en_i    (req_valid_i && region == RG_OUT && (!req_write_i || do_write)),
    .a_we_i    (do_write), // [R2]
    .a_addr_i  (req_addr_i[PD_AW-1:0]),
    .a_wdata_i (req_wdata_i),
    .a_rdata_o (out_rdata),
    .b_en_i    (1'b1),
    .b_we_i    (1'b0),
    .b_addr_i  (out_pd_addr_i),
    .b_wdata_i (16'h0000),
    .b_rdata_o (out_pd_rdata_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Response pipeline, fixed two-cycle latency to match the memory read

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_valid  <= 1'b0;
      s1_write  <= 1'b0;
      s1_region <= RG_NONE;
      s1_exc    <= EXC_NONE;
      s1_rdata  <= 16'h0000;
    end
    else
    begin
      s1_valid  <= req_valid_i;
      s1_write  <= req_write_i;
      s1_region <= region;
      s1_exc    <= req_exc;
      s1_rdata  <= reg_rdata;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rsp_valid_o <= 1'b0;
      rsp_exc_o   <= EXC_NONE;
      rsp_rdata_o <= 16'h0000;
    end
    else
    begin
      rsp_valid_o <= s1_valid;
      rsp_exc_o   <= s1_valid ? s1_exc : EXC_NONE;
      if (!s1_valid || s1_write || s1_exc != EXC_NONE)
        rsp_rdata_o <= 16'h0000;
      else if (s1_region == RG_IN)
        rsp_rdata_o <= in_rdata;
      else if (s1_region == RG_OUT)
        rsp_rdata_o <= out_rdata;
      else
        rsp_rdata_o <= s1_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write authorization

  assign conn_rise = conn_open_i & ~conn_q;

  always_comb
  begin
    logic taken;
    taken     = |write_auth_o;
    next_auth = write_auth_o;
    if (do_write)
    begin
      next_auth[req_conn_i] = 1'b1; // [R6]
      taken = 1'b1;
    end
    for (int i = 0; i < NCONN; i++)
    begin
      // In single mode the lowest slot wins when several connect in one cycle
      if (conn_rise[i] && connection_mode_o[MODE_IMMEDIATE_BIT] &&
          (!connection_mode_o[MODE_SINGLE_BIT] || !taken))
      begin
        next_auth[i] = 1'b1; // [R7]
        taken = 1'b1;
      end
      if (!conn_open_i[i])
        next_auth[i] = 1'b0; // [R5]
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      write_auth_o <= '0;
      conn_q       <= '0;
    end
    else
    begin
      write_auth_o <= next_auth;
      conn_q       <= conn_open_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Seconds tick and idle timeout

  assign sec_tick = sec_cnt == SEC_CYCLES - 1;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sec_cnt <= '0;
    else if (sec_tick)
      sec_cnt <= '0;
    else
      sec_cnt <= sec_cnt + 32'h0000_0001;
  end

  // Shared tick phase: a close comes up to one second early
  for (genvar g = 0; g < NCONN; g++)
  begin : g_idle
    assign idle_hit[g] = conn_open_i[g] && idle_timeout_s_o != 16'h0000 &&
                         idle_cnt[g] >= idle_timeout_s_o; // [R8]

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        idle_cnt[g] <= 16'h0000;
      else if (!conn_open_i[g] || conn_activity_i[g] || idle_hit[g])
        idle_cnt[g] <= 16'h0000;
      else if (sec_tick && idle_cnt[g] != 16'hffff)
        idle_cnt[g] <= idle_cnt[g] + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      conn_close_o          <= '0;
      timeout_seen          <= 1'b0;
      bus_led_flash_green_o <= 1'b0;
    end
    else
    begin
      conn_close_o <= idle_hit; // [R8]
      // Set wins over the clear of a new connection
      if (|idle_hit)
        timeout_seen <= 1'b1;
      else if (|conn_rise)
        timeout_seen <= 1'b0;
      bus_led_flash_green_o <= protocol_active_o[PROTO_MODBUS_BIT] && timeout_seen &&
                               !(|conn_open_i); // [R9]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Restore (k=0) and save (k=1) key sequences

  // A multi-register write arrives as ascending word writes, key 1 first
  for (genvar k = 0; k < 2; k++)
  begin : g_key
    localparam logic [15:0] A1 = (k == 0) ? ADDR_RESTORE_KEY1 : ADDR_SAVE_KEY1;
    localparam logic [15:0] A2 = (k == 0) ? ADDR_RESTORE_KEY2 : ADDR_SAVE_KEY2;
    localparam logic [15:0] K1 = (k == 0) ? RESTORE_KEY1 : SAVE_KEY1;
    localparam logic [15:0] K2 = (k == 0) ? RESTORE_KEY2 : SAVE_KEY2;
    logic [4:0] win;

    assign key_fire[k] = do_write && req_addr_i == A2 && req_wdata_i == K2 &&
                         key_armed[k]; // [R10] [R12] [R13]

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        key_armed[k] <= 1'b0;
        win          <= 5'h00;
      end
      else if (do_write && req_addr_i == A1)
      begin
        key_armed[k] <= req_wdata_i == K1;
        win          <= KEY_WINDOW_S;
      end
      else if (do_write && req_addr_i == A2)
        key_armed[k] <= 1'b0; // [R15]
      else if (key_armed[k] && sec_tick)
      begin
        if (win == 5'h01)
          key_armed[k] <= 1'b0; // [R15]
        win <= win - 5'h01;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      nvm_save_o <= 1'b0;
    else
      nvm_save_o <= key_fire[1]; // [R12]
  end

  //////////////////////////////////////////////////////////////////////////////
  // Parameter registers

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      watchdog_preset_ms_o <= WD_PRESET_DEF; // [R14]
      connection_mode_o    <= CONN_MODE_DEF;
      idle_timeout_s_o     <= IDLE_TIMEOUT_DEF;
      protocol_disable_o   <= PROTO_DISABLE_DEF;
      protocol_active_o    <= PROTO_ACTIVE_DEF;
    end
    else if (key_fire[0])
    begin
      // Working copies only; the stored image changes only on save
      watchdog_preset_ms_o <= WD_PRESET_DEF; // [R10] [R11]
      connection_mode_o    <= CONN_MODE_DEF;
      idle_timeout_s_o     <= IDLE_TIMEOUT_DEF;
    end
    else if (do_write && region == RG_REG)
    begin
      case (req_addr_i)
        ADDR_WD_PRESET:     watchdog_preset_ms_o <= req_wdata_i;
        ADDR_CONN_MODE:     connection_mode_o    <= req_wdata_i[1:0];
        ADDR_IDLE_TIMEOUT:  idle_timeout_s_o     <= req_wdata_i;
        ADDR_PROTO_DISABLE: protocol_disable_o   <= req_wdata_i;
        ADDR_PROTO_ACTIVE:  protocol_active_o    <= req_wdata_i;
        default:            ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_restore_fire;
    req_valid_i && req_write_i && req_addr_i == ADDR_RESTORE_KEY2 &&
    req_wdata_i == RESTORE_KEY2 && key_armed[0] && auth_ok;
  endsequence

  sequence s_save_fire;
    req_valid_i && req_write_i && req_addr_i == ADDR_SAVE_KEY2 &&
    req_wdata_i == SAVE_KEY2 && key_armed[1] && auth_ok;
  endsequence

  property p_alt_in_ro;
    req_valid_i && req_write_i && req_addr_i >= ALT_IN_BASE && req_addr_i <= ALT_IN_LAST
      |-> ##2 rsp_valid_o && rsp_exc_o == EXC_ILLEGAL_ADDR;
  endproperty
  a_alt_in_ro: assert property (p_alt_in_ro) else $error("alt input write accepted"); // [R1]

  property p_sec_supply;
    req_valid_i && !req_write_i && req_addr_i == ADDR_SEC_SUPPLY
      |-> ##2 rsp_rdata_o == ($past(secondary_uv_i, 2) ? 16'h0000 :
                              $past(secondary_supply_mv_i, 2));
  endproperty
  a_sec_supply: assert property (p_sec_supply) else $error("secondary supply wrong"); // [R3]

  property p_all_write;
    req_valid_i && req_write_i && addr_ok && !connection_mode_o[MODE_SINGLE_BIT]
      |-> ##2 rsp_valid_o && rsp_exc_o == EXC_NONE;
  endproperty
  a_all_write: assert property (p_all_write) else $error("write refused in shared mode"); // [R4]

  property p_single_holder;
    connection_mode_o[MODE_SINGLE_BIT] && $onehot0(write_auth_o) |=> $onehot0(write_auth_o);
  endproperty
  a_single_holder: assert property (p_single_holder) else $error("two write holders"); // [R5]

  property p_refuse;
    req_valid_i && req_write_i && addr_ok && connection_mode_o[MODE_SINGLE_BIT] &&
    !write_auth_o[req_conn_i] && |write_auth_o
      |-> ##2 rsp_valid_o && rsp_exc_o == EXC_NO_AUTH;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refusal not reported"); // [R6]

  property p_no_close;
    idle_timeout_s_o == 16'h0000 |=> conn_close_o == '0;
  endproperty
  a_no_close: assert property (p_no_close) else $error("close with timeout zero"); // [R8]

  property p_bus_led;
    protocol_active_o[PROTO_MODBUS_BIT] && timeout_seen && conn_open_i == '0
      |=> bus_led_flash_green_o;
  endproperty
  a_bus_led: assert property (p_bus_led) else $error("bus indicator not flashing"); // [R9]

  property p_restore;
    s_restore_fire |=> watchdog_preset_ms_o == WD_PRESET_DEF &&
                       connection_mode_o == CONN_MODE_DEF && !nvm_save_o;
  endproperty
  a_restore: assert property (p_restore) else $error("restore not applied"); // [R10]

  property p_save;
    s_save_fire |=> nvm_save_o ##1 !nvm_save_o;
  endproperty
  a_save: assert property (p_save) else $error("save pulse missing"); // [R12]

  property p_abandon;
    do_write && req_addr_i == ADDR_RESTORE_KEY2 |=> !key_armed[0];
  endproperty
  a_abandon: assert property (p_abandon) else $error("restore still armed"); // [R15]

endmodule

// ==== test/mcrb_client.sv ====
// Modbus client model: opens connections on request and honours device disconnects
`timescale 1ns/10ps
module mcrb_client (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] want_open_i,
  input  wire logic [1:0] conn_close_i,
  output logic      [1:0] conn_open_o
);
  logic [1:0] dropped;

  // A dropped client stays away until the bench withdraws and reissues it
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      conn_open_o <= 2'h0;
      dropped     <= 2'h0;
    end
    else
    begin
      dropped     <= (dropped | conn_close_i) & want_open_i;
      conn_open_o <= want_open_i & ~(dropped | conn_close_i);
    end
endmodule

// ==== test/mcrb_bench.sv ====
// Self-checking bench for the connection register bank
`timescale 1ns/10ps
module mcrb_bench;
  import mcrb_pkg::*;
  logic        mclk_i, rst_n_i, req_valid_i, req_write_i, req_conn_i, rsp_valid_o, nvm_save_o;
  logic        power_led_undervolt_style_i, primary_uv_i, secondary_uv_i, in_pd_we_i;
  logic        bus_led_flash_green_o;
  logic [1:0]  conn_open_i, conn_activity_i, conn_close_o, write_auth_o, connection_mode_o;
  logic [1:0]  want_open;
  logic [7:0]  rsp_exc_o, ex;
  logic [8:0]  in_pd_addr_i, out_pd_addr_i;
  logic [15:0] req_addr_i, req_wdata_i, rsp_rdata_o, module_status_i, watchdog_elapsed_ms_i;
  logic [15:0] primary_supply_mv_i, secondary_supply_mv_i, in_pd_wdata_i, out_pd_rdata_o, rd;
  logic [15:0] watchdog_preset_ms_o, idle_timeout_s_o, protocol_disable_o, protocol_active_o;
  int          mismatches, n_tests, cycles, saves, i;

  // One second is 20 cycles so the 30 s key window fits the run
  mcrb_top #(.NCONN(2), .SEC_CYCLES(20)) DUT (.*);
  mcrb_client PARTNER (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .want_open_i(want_open),
                       .conn_close_i(conn_close_o), .conn_open_o(conn_open_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // With two set, two words go back to back, as a multi-register write arrives
  task automatic xfer(input logic w, c, input logic [15:0] a, d0, d1, input logic two);
    @(posedge mclk_i);
    req_valid_i     <= 1'b1;
    req_write_i     <= w;
    req_conn_i      <= c;
    req_addr_i      <= a;
    req_wdata_i     <= d0;
    conn_activity_i <= 2'h1 << c;
    @(posedge mclk_i);
    req_addr_i      <= a + 16'h0001;
    req_wdata_i     <= d1;
    if (two)
      @(posedge mclk_i);
    req_valid_i     <= 1'b0;
    conn_activity_i <= 2'h0;
    // Answer stands only in the second cycle after the last request edge
    @(posedge mclk_i);
    #1;
    rd = rsp_rdata_o;
    ex = rsp_valid_o ? rsp_exc_o : 8'hff;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    xfer(1'b0, 1'b0, a, 16'h0000, 16'h0000, 1'b0);
    chk("rdata", exp, rd);
  endtask

  task automatic wr(input logic c, input logic [15:0] a, d, input logic [7:0] e);
    xfer(1'b1, c, a, d, 16'h0000, 1'b0);
    chk("exc", {8'h00, e}, {8'h00, ex});
  endtask

  task automatic link(input logic [1:0] v);
    @(posedge mclk_i);
    want_open <= v;
    repeat (4) @(posedge mclk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i)
  begin
    cycles++;
    saves += int'(nvm_save_o);
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end

  initial
  begin
    {rst_n_i, req_valid_i, req_write_i, req_conn_i, in_pd_we_i, primary_uv_i} = '0;
    {secondary_uv_i, power_led_undervolt_style_i, conn_activity_i, want_open} = '0;
    {req_addr_i, req_wdata_i, in_pd_addr_i, in_pd_wdata_i, module_status_i} = '0;
    {watchdog_elapsed_ms_i, primary_supply_mv_i} = '0;
    out_pd_addr_i = 9'h003;
    secondary_supply_mv_i = 16'h2ee0;
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    link(2'h3);
    chk("preset", 16'h01f4, watchdog_preset_ms_o);
    rdc(ADDR_IDLE_TIMEOUT, 16'h0000);
    rdc(ADDR_PROTO_ACTIVE, PROTO_ACTIVE_DEF);
    @(posedge mclk_i);
    in_pd_addr_i  <= 9'h005;
    in_pd_wdata_i <= 16'ha5a5;
    in_pd_we_i    <= 1'b1;
    @(posedge mclk_i);
    in_pd_we_i    <= 1'b0;
    rdc(16'h8005, 16'ha5a5);
    rdc(16'h0005, 16'ha5a5);
    wr(1'b0, 16'h8005, 16'h0000, EXC_ILLEGAL_ADDR);
    wr(1'b1, 16'h9003, 16'h3c3c, EXC_NONE);
    rdc(16'h0803, 16'h3c3c);
    chk("out_image", 16'h3c3c, out_pd_rdata_o);
    wr(1'b0, ADDR_WD_PRESET, 16'h0064, EXC_NONE);
    chk("auth", 16'h0003, {14'h0, write_auth_o});
    rdc(ADDR_SEC_SUPPLY, 16'h2ee0);
    @(posedge mclk_i);
    secondary_uv_i <= 1'b1;
    rdc(ADDR_SEC_SUPPLY, 16'h0000);
    wr(1'b0, ADDR_SEC_SUPPLY, 16'h0001, EXC_ILLEGAL_ADDR);
    link(2'h0);
    link(2'h3);
    wr(1'b0, ADDR_CONN_MODE, 16'h0001, EXC_NONE);
    wr(1'b1, ADDR_WD_PRESET, 16'h0077, EXC_NO_AUTH);
    chk("auth", 16'h0001, {14'h0, write_auth_o});
    link(2'h2);
    wr(1'b1, ADDR_WD_PRESET, 16'h0077, EXC_NONE);
    chk("auth", 16'h0002, {14'h0, write_auth_o});
    wr(1'b1, ADDR_CONN_MODE, 16'h0003, EXC_NONE);
    link(2'h0);
    link(2'h3);
    chk("auth", 16'h0001, {14'h0, write_auth_o});
    wr(1'b1, ADDR_WD_PRESET, 16'h0088, EXC_NO_AUTH);
    wr(1'b0, ADDR_WD_PRESET, 16'h1234, EXC_NONE);
    wr(1'b0, ADDR_RESTORE_KEY1, RESTORE_KEY1, EXC_NONE);
    wr(1'b0, ADDR_RESTORE_KEY2, 16'h1111, EXC_NONE);
    wr(1'b0, ADDR_RESTORE_KEY2, RESTORE_KEY2, EXC_NONE);
    rdc(ADDR_WD_PRESET, 16'h1234);
    wr(1'b0, ADDR_RESTORE_KEY1, RESTORE_KEY1, EXC_NONE);
    wr(1'b0, ADDR_RESTORE_KEY2, RESTORE_KEY2, EXC_NONE);
    rdc(ADDR_WD_PRESET, 16'h01f4);
    rdc(ADDR_CONN_MODE, 16'h0000);
    chk("saves", 16'h0000, 16'(saves));
    wr(1'b0, ADDR_WD_PRESET, 16'h0042, EXC_NONE);
    wr(1'b0, ADDR_RESTORE_KEY1, RESTORE_KEY1, EXC_NONE);
    repeat (700) @(posedge mclk_i);
    wr(1'b0, ADDR_RESTORE_KEY2, RESTORE_KEY2, EXC_NONE);
    rdc(ADDR_WD_PRESET, 16'h0042);
    xfer(1'b1, 1'b0, ADDR_SAVE_KEY1, SAVE_KEY1, SAVE_KEY2, 1'b1);
    chk("saves", 16'h0001, 16'(saves));
    wr(1'b0, ADDR_IDLE_TIMEOUT, 16'h0002, EXC_NONE);
    for (i = 0; i < 200 && conn_open_i !== 2'h0; i++)
      @(posedge mclk_i);
    repeat (2) @(posedge mclk_i);
    chk("open", 16'h0000, {14'h0, conn_open_i});
    chk("bus_led", 16'h0001, {15'h0, bus_led_flash_green_o});
    finish_test();
  end
endmodule
